// ---- design/port_e_pin_function_select.sv ----
// pin function selection and general port logic for one 16-pin port
//
// Functional notes
// - pin15 code 000 selects general port
// - pin14 field bits 10:8, 000 general
// - pin13 two-bit field 5:4, 00 general
// - pin12 field bits 2:0, 000 general
// - pin10 code 101 carries serial data out
// - pin8 code 101 carries serial clock
// - pin7 code 101 carries serial data in
// - pins 11,6,5,4 code 000 general
// - direction bit n: 0 input, 1 output
// - data bit 12 drives chip select, low selects
// - output pin driven low when data bit zero
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "port_mux_consts.svh"

module port_e_pin_function_select
(
  input  wire logic                   sys_clk_i,
  input  wire logic                   srst_i,
  input  wire logic [`ADDR_WIDTH-1:0] reg_addr_i,
  input  wire logic [`PORT_WIDTH-1:0] reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic      [`PORT_WIDTH-1:0] reg_rdata_o,
  input  wire logic [`PORT_WIDTH-1:0] pin_in_i,
  output logic      [`PORT_WIDTH-1:0] pin_out_o,
  output logic      [`PORT_WIDTH-1:0] pin_oe_o,
  input  wire logic                   ser_data_out_i,
  input  wire logic                   ser_data_out_en_i,
  input  wire logic                   ser_clk_out_i,
  input  wire logic                   ser_clk_out_en_i,
  output logic                        ser_data_in_o,
  output logic                        ser_clk_in_o
);

  localparam port_mux_pkg::port_state_t RESET_STATE = '{
    ctrl_upper:  `UPPER_CTRL_RST,
    ctrl_middle: `MIDDLE_CTRL_RST,
    ctrl_lower:  `LOWER_CTRL_RST,
    direction:   `DIRECTION_RST,
    out_value:   `OUTPUT_VALUE_RST,
    pin_out:     '0,
    pin_oe:      '0,
    rd_data:     '0,
    ser_data_in: 1'b0,
    ser_clk_in:  1'b0
  };

  port_mux_pkg::port_state_t  st;
  port_mux_pkg::port_state_t  next_st;
  logic [`PORT_WIDTH-1:0]     pin_sync_val;
  logic [`PORT_WIDTH-1:0][2:0] func_code;
  logic [`PORT_WIDTH-1:0]     ser_out_vec;
  logic [`PORT_WIDTH-1:0]     ser_oe_vec;
  logic [`PORT_WIDTH-1:0]     slice_out;
  logic [`PORT_WIDTH-1:0]     slice_oe;

  // pins come from outside the clock domain
  pin_sync #(
    .WIDTH (`PORT_WIDTH)
  ) u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .async_i   (pin_in_i),
    .sync_o    (pin_sync_val)
  );

  // unpack the mode fields; pins 3..0 have no field and stay general
  always_comb
  begin
    func_code     = '0;
    func_code[15] = st.ctrl_upper[`PIN15_CODE_LSB +: `CODE_WIDTH];
    func_code[14] = st.ctrl_upper[`PIN14_CODE_LSB +: `CODE_WIDTH];
    func_code[13] = {1'b0, st.ctrl_upper[`PIN13_CODE_LSB +: `PIN13_CODE_WIDTH]};
    func_code[12] = st.ctrl_upper[`PIN12_CODE_LSB +: `CODE_WIDTH];
    func_code[11] = st.ctrl_middle[`PIN11_CODE_LSB +: `CODE_WIDTH];
    func_code[10] = st.ctrl_middle[`PIN10_CODE_LSB +: `CODE_WIDTH];
    func_code[9]  = st.ctrl_middle[`PIN9_CODE_LSB +: `CODE_WIDTH];
    func_code[8]  = st.ctrl_middle[`PIN8_CODE_LSB +: `CODE_WIDTH];
    func_code[7]  = st.ctrl_lower[`PIN7_CODE_LSB +: `CODE_WIDTH];
    func_code[6]  = st.ctrl_lower[`PIN6_CODE_LSB +: `CODE_WIDTH];
    func_code[5]  = st.ctrl_lower[`PIN5_CODE_LSB +: `CODE_WIDTH];
    func_code[4]  = st.ctrl_lower[`PIN4_CODE_LSB +: `CODE_WIDTH];
  end

  // serial unit drive per pin; the data-in pin is never driven
  always_comb
  begin
    ser_out_vec                  = '0;
    ser_oe_vec                   = '0;
    ser_out_vec[`DATA_OUT_PIN]   = ser_data_out_i;
    ser_oe_vec[`DATA_OUT_PIN]    = ser_data_out_en_i;
    ser_out_vec[`CLOCK_PIN]      = ser_clk_out_i;
    ser_oe_vec[`CLOCK_PIN]       = ser_clk_out_en_i;
  end

  // one slice per pin; only the three serial pins accept code 101
  for (genvar i = 0; i < `PORT_WIDTH; i++)
  begin : g_pin
    pin_slice #(
      .HAS_SERIAL (i == `DATA_OUT_PIN || i == `CLOCK_PIN || i == `DATA_IN_PIN)
    ) u_slice (
      .func_code_i    (func_code[i]),
      .dir_i          (st.direction[i]),
      .out_value_i    (st.out_value[i]),
      .ser_out_i      (ser_out_vec[i]),
      .ser_oe_i       (ser_oe_vec[i]),
      .next_pin_out_o (slice_out[i]),
      .next_pin_oe_o  (slice_oe[i])
    );
  end

  // register writes, reads and registered pin drive
  always_comb
  begin
    next_st         = st;
    next_st.rd_data = '0;
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        `UPPER_CTRL_OFS:   next_st.ctrl_upper  = reg_wdata_i & `UPPER_CTRL_MASK;
        `MIDDLE_CTRL_OFS:  next_st.ctrl_middle = reg_wdata_i & `MIDDLE_CTRL_MASK;
        `LOWER_CTRL_OFS:   next_st.ctrl_lower  = reg_wdata_i & `LOWER_CTRL_MASK;
        `DIRECTION_OFS:    next_st.direction   = reg_wdata_i;
        `OUTPUT_VALUE_OFS: next_st.out_value   = reg_wdata_i;
        default:           next_st.rd_data     = '0;
      endcase
    end
    // read data stand one cycle only; unmapped reads return zero
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        `UPPER_CTRL_OFS:   next_st.rd_data = st.ctrl_upper;
        `MIDDLE_CTRL_OFS:  next_st.rd_data = st.ctrl_middle;
        `LOWER_CTRL_OFS:   next_st.rd_data = st.ctrl_lower;
        `DIRECTION_OFS:    next_st.rd_data = st.direction;
        `OUTPUT_VALUE_OFS: next_st.rd_data = st.out_value;
        `PIN_STATE_OFS:    next_st.rd_data = pin_sync_val;
        default:           next_st.rd_data = '0;
      endcase
    end
    // one cycle of latency buys glitch-free outputs from flops
    next_st.pin_out     = slice_out;
    next_st.pin_oe      = slice_oe;
    // inputs to the serial unit only when the pin is assigned to it
    next_st.ser_data_in = (func_code[`DATA_IN_PIN] == port_mux_pkg::FUNC_SERIAL)
                          & pin_sync_val[`DATA_IN_PIN];
    next_st.ser_clk_in  = (func_code[`CLOCK_PIN] == port_mux_pkg::FUNC_SERIAL)
                          & pin_sync_val[`CLOCK_PIN];
  end

  // state register, synchronous reset
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      st <= RESET_STATE;
    else
      st <= next_st;
  end

  // outputs straight from state flops
  assign reg_rdata_o   = st.rd_data;
  assign pin_out_o     = st.pin_out;
  assign pin_oe_o      = st.pin_oe;
  assign ser_data_in_o = st.ser_data_in;
  assign ser_clk_in_o  = st.ser_clk_in;

  // checks on pin drive against the registers of the cycle before
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  pin15_gpio_a: assert property (
    (func_code[15] == 3'h0) |=> (pin_oe_o[15] == $past(st.direction[15]))
                               && (pin_out_o[15] == ($past(st.direction[15]) & $past(st.out_value[15]))))
    else $error("pin 15 not under port control with code zero");

  pin14_gpio_a: assert property (
    (st.ctrl_upper[10:8] == 3'h0 && !st.direction[14]) |=> !pin_oe_o[14])
    else $error("pin 14 driven while general input");

  pin13_gpio_a: assert property (
    (st.ctrl_upper[5:4] == 2'h0 && st.direction[13]) |=> pin_oe_o[13]
                                                        && (pin_out_o[13] == $past(st.out_value[13])))
    else $error("pin 13 not driven as general output");

  pin12_gpio_a: assert property (
    (st.ctrl_upper[2:0] == 3'h0 && !st.direction[12]) |=> !pin_oe_o[12])
    else $error("pin 12 driven while general input");

  data_out_pin_a: assert property (
    (st.ctrl_middle[10:8] == 3'h5) |=> (pin_out_o[10] == $past(ser_data_out_i))
                                      && (pin_oe_o[10] == $past(ser_data_out_en_i)))
    else $error("pin 10 does not follow serial data out");

  clock_pin_a: assert property (
    (st.ctrl_middle[2:0] == 3'h5 && pin_in_i[8]) ##1 (st.ctrl_middle[2:0] == 3'h5 && pin_in_i[8])
    ##1 (st.ctrl_middle[2:0] == 3'h5) |=> ser_clk_in_o && (pin_oe_o[8] == $past(ser_clk_out_en_i)))
    else $error("pin 8 not connected to serial clock");

  data_in_pin_a: assert property (
    (st.ctrl_lower[14:12] == 3'h5) |=> !pin_oe_o[7])
    else $error("serial data in pin driven");

  other_gpio_a: assert property (
    (st.ctrl_middle[14:12] == 3'h0 && st.ctrl_lower[10:8] == 3'h0
     && st.ctrl_lower[6:4] == 3'h0 && st.ctrl_lower[2:0] == 3'h0)
    |=> ({pin_oe_o[11], pin_oe_o[6:4]} == {$past(st.direction[11]), $past(st.direction[6:4])}))
    else $error("pins 11 and 6 to 4 not under port direction");

  dir_write_a: assert property (
    (reg_wr_i && reg_addr_i == `DIRECTION_OFS) |=> ##1 (pin_oe_o[3:0] == $past(reg_wdata_i[3:0], 2)))
    else $error("direction write not reflected on pins 3 to 0");

  chip_select_a: assert property (
    (reg_wr_i && reg_addr_i == `OUTPUT_VALUE_OFS && !reg_wdata_i[12]
     && st.ctrl_upper[2:0] == 3'h0 && st.direction[12])
    ##1 (st.ctrl_upper[2:0] == 3'h0 && st.direction[12]) |=> pin_oe_o[12] && !pin_out_o[12])
    else $error("chip select not driven low");

  low_drive_a: assert property (
    (func_code[15] == 3'h0 && st.direction[15] && !st.out_value[15]) |=> pin_oe_o[15] && !pin_out_o[15])
    else $error("output pin not driven low for zero data");

  serial_owns_a: assert property (
    (st.ctrl_middle[10:8] == 3'h5 && st.direction[10] && !ser_data_out_en_i) |=> !pin_oe_o[10])
    else $error("port direction drove a serial pin");

  read_value_a: assert property (
    (reg_rd_i && reg_addr_i == `OUTPUT_VALUE_OFS) |=> (reg_rdata_o == $past(st.out_value)) ##1 1'b1)
    else $error("data register read back wrong");

  // register port: read data stand one cycle, unmapped reads give zero
  read_idle_a: assert property (
    !reg_rd_i |=> (reg_rdata_o == 16'h0000))
    else $error("read data stood without a read strobe");

  unmapped_read_a: assert property (
    (reg_rd_i && reg_addr_i > `PIN_STATE_OFS) |=> (reg_rdata_o == 16'h0000))
    else $error("unmapped register read not zero");

  upper_mask_a: assert property (
    (reg_wr_i && reg_addr_i == `UPPER_CTRL_OFS)
    |=> (st.ctrl_upper == ($past(reg_wdata_i) & `UPPER_CTRL_MASK)))
    else $error("upper mode register kept reserved bits");

  dir_read_a: assert property (
    (reg_rd_i && reg_addr_i == `DIRECTION_OFS) |=> (reg_rdata_o == $past(st.direction)))
    else $error("direction register read back wrong");

  pin_state_read_a: assert property (
    (reg_rd_i && reg_addr_i == `PIN_STATE_OFS) |=> (reg_rdata_o == $past(pin_sync_val)))
    else $error("pin state read back wrong");

  // foreign codes release a pin; general pins follow direction and data
  pin15_release_a: assert property (
    (func_code[15] != 3'h0) |=> (!pin_oe_o[15] && !pin_out_o[15]))
    else $error("pin 15 driven under a foreign code");

  pin14_output_a: assert property (
    (st.ctrl_upper[10:8] == 3'h0 && st.direction[14])
    |=> (pin_oe_o[14] && (pin_out_o[14] == $past(st.out_value[14]))))
    else $error("pin 14 not driven as general output");

  pin13_release_a: assert property (
    (st.ctrl_upper[5:4] != 2'h0) |=> (!pin_oe_o[13] && !pin_out_o[13]))
    else $error("pin 13 driven under a foreign code");

  pin12_output_a: assert property (
    (st.ctrl_upper[2:0] == 3'h0 && st.direction[12])
    |=> (pin_oe_o[12] && (pin_out_o[12] == $past(st.out_value[12]))))
    else $error("pin 12 not driven as general output");

  chip_deselect_a: assert property (
    (st.ctrl_upper[2:0] == 3'h0 && st.direction[12] && st.out_value[12])
    |=> (pin_oe_o[12] && pin_out_o[12]))
    else $error("chip select not driven high");

  clock_drive_a: assert property (
    (st.ctrl_middle[2:0] == 3'h5)
    |=> (pin_out_o[8] == $past(ser_clk_out_i)) && (pin_oe_o[8] == $past(ser_clk_out_en_i)))
    else $error("pin 8 does not follow serial clock out");

  clock_owns_a: assert property (
    (st.ctrl_middle[2:0] == 3'h5 && st.direction[8] && !ser_clk_out_en_i) |=> !pin_oe_o[8])
    else $error("port direction drove the clock pin");

  clock_in_gate_a: assert property (
    (st.ctrl_middle[2:0] != 3'h5) |=> !ser_clk_in_o)
    else $error("serial clock in passed from a port pin");

  data_in_follow_a: assert property (
    (st.ctrl_lower[14:12] == 3'h5) |=> (ser_data_in_o == $past(pin_sync_val[7])))
    else $error("serial data in does not follow pin 7");

  data_in_gate_a: assert property (
    (st.ctrl_lower[14:12] != 3'h5) |=> !ser_data_in_o)
    else $error("serial data in passed from a port pin");

  pin11_gpio_a: assert property (
    (st.ctrl_middle[14:12] == 3'h0)
    |=> (pin_out_o[11] == ($past(st.direction[11]) & $past(st.out_value[11]))))
    else $error("pin 11 level not under port data");

  pin4_release_a: assert property (
    (st.ctrl_lower[2:0] != 3'h0) |=> (!pin_oe_o[4] && !pin_out_o[4]))
    else $error("pin 4 driven under a foreign code");

  // pins 3..0 have no field, so they are always general port pins
  low_pins_a: assert property (
    1'b1 |=> (pin_oe_o[3:0] == $past(st.direction[3:0])))
    else $error("pins 3 to 0 not under port direction");

  low_level_a: assert property (
    1'b1 |=> (pin_out_o[3:0] == ($past(st.direction[3:0]) & $past(st.out_value[3:0]))))
    else $error("pins 3 to 0 level not under port data");

  serial_setup_c: cover property (
    st.ctrl_middle[10:8] == 3'h5 && st.ctrl_middle[2:0] == 3'h5 && st.ctrl_lower[14:12] == 3'h5);

  chip_selected_c: cover property (
    pin_oe_o[12] && !pin_out_o[12] ##1 pin_out_o[12]);

  pin_read_c: cover property (
    reg_rd_i && reg_addr_i == `PIN_STATE_OFS ##1 reg_rdata_o != 16'h0000);

  pin13_release_c: cover property (
    st.ctrl_upper[5:4] != 2'h0 ##1 !pin_oe_o[13]);

  clock_in_c: cover property (
    ser_clk_in_o ##1 !ser_clk_in_o);

endmodule : port_e_pin_function_select

// ---- design/port_mux_consts.svh ----
// offsets, field positions, reset values and widths of the port pin function block
`ifndef PORT_MUX_CONSTS_SVH
`define PORT_MUX_CONSTS_SVH

// port and register bus widths, function code field widths and synchroniser stage count
`define PORT_WIDTH        16
`define ADDR_WIDTH        4
`define CODE_WIDTH        3
`define PIN13_CODE_WIDTH  2
`define SYNC_STAGES       2

// register word offsets on the plain register port
`define UPPER_CTRL_OFS    4'h0
`define MIDDLE_CTRL_OFS   4'h1
`define LOWER_CTRL_OFS    4'h2
`define DIRECTION_OFS     4'h3
`define OUTPUT_VALUE_OFS  4'h4
`define PIN_STATE_OFS     4'h5

// writable bits; reserved bits hold and read zero
`define UPPER_CTRL_MASK   16'h7737
`define MIDDLE_CTRL_MASK  16'h7777
`define LOWER_CTRL_MASK   16'h7777

// reset values
`define UPPER_CTRL_RST    16'h0000
`define MIDDLE_CTRL_RST   16'h0000
`define LOWER_CTRL_RST    16'h0000
`define DIRECTION_RST     16'h0000
`define OUTPUT_VALUE_RST  16'h0000

// lowest bit of each function code field
`define PIN15_CODE_LSB    12
`define PIN14_CODE_LSB    8
`define PIN13_CODE_LSB    4
`define PIN12_CODE_LSB    0
`define PIN11_CODE_LSB    12
`define PIN10_CODE_LSB    8
`define PIN9_CODE_LSB     4
`define PIN8_CODE_LSB     0
`define PIN7_CODE_LSB     12
`define PIN6_CODE_LSB     8
`define PIN5_CODE_LSB     4
`define PIN4_CODE_LSB     0

// pins that carry serial unit functions, and the chip select pin driven by port data bit 12
`define DATA_OUT_PIN      10
`define CLOCK_PIN         8
`define DATA_IN_PIN       7
`define CHIP_SELECT_PIN   12

`endif

// ---- design/port_mux_pkg.sv ----
// types shared by the port pin function block
`include "port_mux_consts.svh"

package port_mux_pkg;

  // function codes of a pin mode field
  typedef enum logic [`CODE_WIDTH-1:0]
  {
    FUNC_GPIO   = 3'h0,
    FUNC_SERIAL = 3'h5
  } pin_func_t;

  // complete state of the top module
  typedef struct packed
  {
    logic [`PORT_WIDTH-1:0] ctrl_upper;
    logic [`PORT_WIDTH-1:0] ctrl_middle;
    logic [`PORT_WIDTH-1:0] ctrl_lower;
    logic [`PORT_WIDTH-1:0] direction;
    logic [`PORT_WIDTH-1:0] out_value;
    logic [`PORT_WIDTH-1:0] pin_out;
    logic [`PORT_WIDTH-1:0] pin_oe;
    logic [`PORT_WIDTH-1:0] rd_data;
    logic                   ser_data_in;
    logic                   ser_clk_in;
  } port_state_t;

endpackage : port_mux_pkg

// ---- design/pin_sync.sv ----
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps

module pin_sync
#(
  parameter int WIDTH = 16
)
(
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  typedef struct packed
  {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // first stage feeds only the second stage
  always_comb
  begin
    next_st        = st;
    next_st.meta   = async_i;
    next_st.stable = st.meta;
  end

  // reset to constants only
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign sync_o = st.stable;

endmodule : pin_sync

// ---- design/pin_slice.sv ----
// per-pin choice between general port logic and a serial unit signal
`timescale 1ns/1ps

module pin_slice
#(
  parameter bit HAS_SERIAL = 1'b0
)
(
  input  wire logic [2:0] func_code_i,
  input  wire logic       dir_i,
  input  wire logic       out_value_i,
  input  wire logic       ser_out_i,
  input  wire logic       ser_oe_i,
  output logic            next_pin_out_o,
  output logic            next_pin_oe_o
);

  // unsupported codes release the pin rather than guess a function
  always_comb
  begin
    next_pin_out_o = 1'b0;
    next_pin_oe_o  = 1'b0;
    if (func_code_i == port_mux_pkg::FUNC_GPIO)
    begin
      next_pin_oe_o  = dir_i;
      next_pin_out_o = dir_i & out_value_i;
    end
    else if (HAS_SERIAL && func_code_i == port_mux_pkg::FUNC_SERIAL)
    begin
      // serial unit owns the pin, port bits ignored
      next_pin_out_o = ser_out_i;
      next_pin_oe_o  = ser_oe_i;
    end
  end

endmodule : pin_slice

// ---- bench/eeprom_model.sv ----
// behavioural serial memory that answers on the port's data-in pin
`timescale 1ns/1ps

module eeprom_model
#(
  parameter logic [7:0] PATTERN = 8'ha5
)
(
  input  wire logic sys_clk_i,
  input  wire logic srst_i,
  input  wire logic cs_n_i,
  input  wire logic sck_i,
  output logic      so_o
);
  logic [7:0] shift;
  logic       sck_d;

  // shifts on rising transfer clock while selected; a released line toggles so stale data never passes
  always_ff @(posedge sys_clk_i)
  begin
    sck_d <= sck_i;
    if (srst_i)
    begin
      shift <= PATTERN;
      so_o  <= 1'b0;
    end
    else if (cs_n_i !== 1'b0)
    begin
      shift <= PATTERN;
      so_o  <= ~so_o;
    end
    else if (sck_i && !sck_d)
    begin
      so_o  <= shift[7];
      shift <= {shift[6:0], shift[7]};
    end
  end
endmodule : eeprom_model

// ---- bench/port_e_pin_function_select_test.sv ----
// self-checking bench for the port pin function block
`timescale 1ns/1ps
`include "port_mux_consts.svh"

module port_e_pin_function_select_test;
  logic        sys_clk_i   = 1'b0;
  logic        srst_i      = 1'b1;
  logic        reg_wr_i    = 1'b0;
  logic        reg_rd_i    = 1'b0;
  logic [3:0]  reg_addr_i  = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic [15:0] ext         = 16'h0000;
  logic [3:0]  ser         = 4'h0;
  logic [31:0] rnd         = 32'd81690;
  logic        armed       = 1'b0;
  logic [15:0] rdata;
  logic [15:0] pout;
  logic [15:0] poe;
  logic [15:0] s1;
  logic [15:0] s2;
  logic [15:0] e_rd;
  logic [31:0] e_pins;
  logic [15:0] m_reg [0:4];
  logic        din;
  logic        cin;
  logic        e_din;
  logic        e_cin;
  logic        so;
  int          n_errors    = 0;
  int          n_checks    = 0;
  // pad level: the block wins where it drives, else the outside world
  wire  [15:0] pad = (poe & pout) | (~poe & {ext[15:8], so, ext[6:0]});

  port_e_pin_function_select u_dut
  (
    .sys_clk_i         (sys_clk_i),
    .srst_i            (srst_i),
    .reg_addr_i        (reg_addr_i),
    .reg_wdata_i       (reg_wdata_i),
    .reg_wr_i          (reg_wr_i),
    .reg_rd_i          (reg_rd_i),
    .reg_rdata_o       (rdata),
    .pin_in_i          (pad),
    .pin_out_o         (pout),
    .pin_oe_o          (poe),
    .ser_data_out_i    (ser[3]),
    .ser_data_out_en_i (ser[2]),
    .ser_clk_out_i     (ser[1]),
    .ser_clk_out_en_i  (ser[0]),
    .ser_data_in_o     (din),
    .ser_clk_in_o      (cin)
  );

  eeprom_model u_mem
  (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .cs_n_i    (pad[12]),
    .sck_i     (pad[8]),
    .so_o      (so)
  );

  initial
  begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction : lfsr_next

  // pins 3..0 have no field; other fields sit four bits apart
  function automatic logic [2:0] code(input int p);
    return (p < 4) ? 3'h0 : 3'(m_reg[(15 - p) / 4] >> ((p % 4) * 4));
  endfunction : code

  function automatic logic [15:0] mask(input int a);
    return (a == 0) ? `UPPER_CTRL_MASK : (a == 1) ? `MIDDLE_CTRL_MASK : (a == 2) ? `LOWER_CTRL_MASK : 16'hffff;
  endfunction : mask

  // expected {enable, level} of every pin from model registers and serial outputs
  function automatic logic [31:0] pins();
    logic [15:0] oe;
    logic [15:0] lv;
    oe = 16'h0000;
    lv = 16'h0000;
    for (int p = 0; p < 16; p++)
    begin
      if (code(p) == 3'h0)
      begin
        oe[p] = m_reg[3][p];
        lv[p] = m_reg[3][p] & m_reg[4][p];
      end
      else if (code(p) == 3'h5 && p == 10)
      begin
        oe[p] = ser[2];
        lv[p] = ser[3];
      end
      else if (code(p) == 3'h5 && p == 8)
      begin
        oe[p] = ser[0];
        lv[p] = ser[1];
      end
    end
    return {oe, lv};
  endfunction : pins

  // reference model and random stimulus, both on the rising edge
  always @(posedge sys_clk_i)
  begin
    armed  <= !srst_i;
    e_pins <= srst_i ? 32'h0 : pins();
    e_rd   <= (reg_rd_i && !srst_i) ? ((reg_addr_i < 5) ? m_reg[reg_addr_i] : (reg_addr_i == 5) ? s2 : 16'h0) : 16'h0;
    e_din  <= !srst_i && code(7) == 3'h5 && s2[7];
    e_cin  <= !srst_i && code(8) == 3'h5 && s2[8];
    s1     <= srst_i ? 16'h0 : pad;
    s2     <= srst_i ? 16'h0 : s1;
    for (int a = 0; a < 5; a++)
      if (srst_i || (reg_wr_i && reg_addr_i == a))
        m_reg[a] <= srst_i ? 16'h0 : (reg_wdata_i & mask(a));
    rnd <= lfsr_next(rnd);
    ext <= rnd[15:0];
    ser <= rnd[19:16];
  end

  task automatic chk_word(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t ns: %s is %h, expected %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic got, input logic exp);
    chk_word(what, {15'h0, got}, {15'h0, exp});
  endtask : chk_bit

  // compare once outputs have settled, every cycle out of reset
  always @(negedge sys_clk_i)
    if (armed && !srst_i)
    begin
      chk_word("read data", rdata, e_rd);
      chk_word("pin enable", poe, e_pins[31:16]);
      chk_word("pin level", pout, e_pins[15:0]);
      chk_bit("serial data in", din, e_din);
      chk_bit("serial clock in", cin, e_cin);
    end

  // one bus cycle; a strobe stands until the next call, so bursts end with an idle call
  task automatic acc(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
    reg_wr_i    <= w;
    reg_rd_i    <= r;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
  endtask : acc

  task automatic done(input string t);
    acc(1'b0, 1'b0, 4'h0, 16'h0000);
    repeat (4) @(posedge sys_clk_i);
    $display("test %s finished, errors so far %0d", t, n_errors);
  endtask : done

  task automatic finish_test();
    $display("checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (100000) @(posedge sys_clk_i);
    n_errors++;
    $display("Error at %0t ns: run limit reached", $time);
    finish_test();
  end

  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    @(posedge sys_clk_i);
    for (int a = 0; a < 8; a++)
      acc(1'b0, 1'b1, 4'(a), 16'h0000);
    done("reset values");
    for (int a = 0; a < 6; a++)
      acc(1'b1, 1'b0, 4'(a), 16'hffff);
    for (int a = 0; a < 7; a++)
      acc(1'b0, 1'b1, 4'(a), 16'h0000);
    done("reserved bits");
    // every code on every field, with random direction and data
    for (int c = 0; c < 8; c++)
    begin
      for (int a = 0; a < 3; a++)
        acc(1'b1, 1'b0, 4'(a), 16'(c * 16'h1111));
      for (int k = 0; k < 3; k++)
      begin
        acc(1'b1, 1'b0, 4'h3, rnd[15:0]);
        acc(1'b1, 1'b0, 4'h4, rnd[31:16]);
        acc(1'b0, 1'b1, 4'h5, 16'h0000);
        acc(1'b0, 1'b0, 4'h0, 16'h0000);
        repeat (2) @(posedge sys_clk_i);
      end
    end
    done("code sweep");
    // memory set-up: serial pins routed, chip select as general output
    acc(1'b1, 1'b0, 4'h0, 16'h0000);
    acc(1'b1, 1'b0, 4'h1, 16'h0505);
    acc(1'b1, 1'b0, 4'h2, 16'h5000);
    acc(1'b1, 1'b0, 4'h3, 16'h1000);
    acc(1'b1, 1'b0, 4'h4, 16'h1000);
    acc(1'b0, 1'b0, 4'h0, 16'h0000);
    repeat (19) @(posedge sys_clk_i);
    acc(1'b1, 1'b0, 4'h4, 16'h0000);
    for (int k = 0; k < 100; k++)
      acc(1'b0, k[0], 4'h5, 16'h0000);
    acc(1'b1, 1'b0, 4'h4, 16'h1000);
    done("memory select");
    // reset in mid-run returns every register to zero
    srst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    @(posedge sys_clk_i);
    for (int a = 0; a < 6; a++)
      acc(1'b0, 1'b1, 4'(a), 16'h0000);
    done("second reset");
    finish_test();
  end
endmodule : port_e_pin_function_select_test
